// file: logic/hcp_pkg.sv
// Behaviour
// [RULE_01] I2C: start, address+rw, sub-address, data, stop
// [RULE_02] Programmable even write address, read is plus one
// [RULE_03] Write sub-address is read code with MSB set
// [RULE_04] Multi-byte parameters travel low byte first
// [RULE_05] One shared 512-byte buffer, next command overwrites
// [RULE_06] Device stretches SCL on read; host waits
// [RULE_07] Host fetches result with read address, then stop
// [RULE_08] Read parameters follow sub-address, select returned data
// [RULE_09] I2C write is one phase, no read phase
// [RULE_10] START is SDA falling while SCL high
// [RULE_11] Every USB transfer leads with report id zero
// [RULE_12] USB header: flag, sequence, two-byte length
// [RULE_13] Length counts command code and data only
// [RULE_14] Payload: command code first, then its data
// [RULE_15] Response echoes the host's sequence byte
// [RULE_16] Read and write commands both go outbound
// [RULE_17] Read response sent only on inbound request
// [RULE_18] At most 64 bytes per transfer, split longer
// [RULE_19] Only first transfer holds header and code
// [RULE_20] Flag bit7 read, bit6 reply wanted, 2:0 zero
// [RULE_21] Response flag echoes, bit5 marks failure
package hcp_pkg;

  // Clock and link timing
  localparam int CLK_NS = 8;
  localparam int I2C_KHZ = 400;
  localparam int I2C_PERIOD_NS = 1000000 / I2C_KHZ;
  localparam logic [7:0] QTR_CYC = 8'((I2C_PERIOD_NS / 4 + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] IN_WAIT_CYC = 8'h40;

  // I2C target
  localparam logic [7:0] I2C_WR_ADDR_DEF = 8'h34;
  localparam int SUB_WR_BIT = 7;

  // Shared command buffer
  localparam int BUF_BYTES = 512;

  // USB framing
  localparam logic [7:0] REPORT_ID = 8'h00;
  localparam logic [6:0] USB_XFER_MAX = 7'h40;
  localparam int FLAG_READ_BIT = 7;
  localparam int FLAG_REPLY_BIT = 6;
  localparam int FLAG_ERR_BIT = 5;

  // Host controller registers
  localparam logic [9:0] HREG_CTRL = 10'h200;
  localparam logic [9:0] HREG_COUNT = 10'h201;
  localparam logic [9:0] HREG_STATUS = 10'h202;
  localparam logic [9:0] HREG_INCNT = 10'h203;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NACK_BIT = 1;

  // Host operations
  localparam logic [1:0] OP_I2C_WR = 2'h0;
  localparam logic [1:0] OP_I2C_RD = 2'h1;
  localparam logic [1:0] OP_USB_OUT = 2'h2;
  localparam logic [1:0] OP_USB_IN = 2'h3;
endpackage : hcp_pkg

// file: logic/host_link_if.sv
`timescale 1ns/10ps
interface host_link_if;
  // Open-drain I2C pins, one driver set per end
  logic scl_o_h;
  logic scl_oe_h;
  logic sda_o_h;
  logic sda_oe_h;
  logic scl_o_d;
  logic scl_oe_d;
  logic sda_o_d;
  logic sda_oe_d;
  logic scl;
  logic sda;
  // USB report byte streams
  logic [7:0] usb_out_data;
  logic usb_out_valid;
  logic usb_out_last;
  logic usb_in_req;
  logic [7:0] usb_in_data;
  logic usb_in_valid;
  logic usb_in_last;

  // Wired-AND bus level with pull-up when nobody drives
  assign scl = (!scl_oe_h || scl_o_h) && (!scl_oe_d || scl_o_d);
  assign sda = (!sda_oe_h || sda_o_h) && (!sda_oe_d || sda_o_d);

  modport dev (
    input scl, sda, usb_out_data, usb_out_valid, usb_out_last, usb_in_req,
    output scl_o_d, scl_oe_d, sda_o_d, sda_oe_d, usb_in_data, usb_in_valid, usb_in_last
  );
  modport host (
    input scl, sda, usb_in_data, usb_in_valid, usb_in_last,
    output scl_o_h, scl_oe_h, sda_o_h, sda_oe_h, usb_out_data, usb_out_valid,
    output usb_out_last, usb_in_req
  );
endinterface : host_link_if

// file: logic/host_cmd_dev.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module host_cmd_dev
  import hcp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to host
  host_link_if.dev link,
  // Configuration
  input wire logic [7:0] i2c_wr_addr,
  // Command to executor
  output logic cmd_valid,
  output logic [15:0] cmd_code,
  output logic [9:0] cmd_len,
  output logic cmd_read,
  output logic cmd_usb,
  output logic busy,
  // Parameter read port
  input wire logic [8:0] buf_raddr,
  output logic [7:0] buf_rdata,
  // Response from executor
  input wire logic rsp_we,
  input wire logic [8:0] rsp_addr,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_valid,
  input wire logic [9:0] rsp_len,
  input wire logic rsp_err
);
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACKW, I_ACK, I_TX, I_MACK, I_TXLD} i2c_st_e;
  typedef enum logic [3:0] {U_ID, U_FLAG, U_SEQ, U_LLO, U_LHI, U_CLO, U_CHI, U_DATA,
    U_DROP} usb_st_e;
  typedef enum logic [2:0] {T_IDLE, T_ID, T_FLAG, T_SEQ, T_LLO, T_LHI, T_DATA} tx_st_e;

  typedef struct packed {
    logic [2:0] scl_sy;
    logic [2:0] sda_sy;
    i2c_st_e ist;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] sub;
    logic [9:0] bytec;
    logic [9:0] txptr;
    logic rdph;
    logic sda_oe;
    logic scl_oe;
    logic busy;
    logic cmd_valid;
    logic [15:0] cmd_code;
    logic [9:0] cmd_len;
    logic cmd_read;
    logic cmd_usb;
    usb_st_e ust;
    logic [6:0] ucnt;
    logic mid;
    logic [15:0] plen;
    logic [15:0] pcnt;
    logic [7:0] flag;
    logic [7:0] seq;
    logic [7:0] clo;
    logic [9:0] rlen;
    logic rerr;
    logic pend;
    tx_st_e tst;
    logic [9:0] tptr;
    logic [6:0] icnt;
    logic first;
    logic ph;
    logic [7:0] in_data;
    logic in_valid;
    logic in_last;
  } dev_s;

  dev_s q;
  dev_s n;
  logic [7:0] mem [BUF_BYTES];
  logic [7:0] mem_q;
  logic [7:0] buf_rdata_r;
  logic bw_en;
  logic [8:0] bw_addr;
  logic [7:0] bw_data;
  logic [8:0] rd_addr;
  logic scl_v;
  logic sda_v;
  logic start;
  logic stop;
  logic rise;
  logic fall;

  // Edges seen on the second and third sync stages only
  assign scl_v = q.scl_sy[1];
  assign sda_v = q.sda_sy[1];
  assign start = q.scl_sy[2] && scl_v && q.sda_sy[2] && !sda_v; // RULE_10
  assign stop = q.scl_sy[2] && scl_v && !q.sda_sy[2] && sda_v;
  assign rise = !q.scl_sy[2] && scl_v;
  assign fall = q.scl_sy[2] && !scl_v;
  assign rd_addr = (q.tst == T_DATA) ? q.tptr[8:0] : q.txptr[8:0];

  // Next state of both transports and the response path
  always_comb begin
    n = q;
    bw_en = 1'b0;
    bw_addr = '0;
    bw_data = '0;
    n.cmd_valid = 1'b0;
    n.in_valid = 1'b0;
    n.in_last = 1'b0;
    n.scl_sy = {q.scl_sy[1:0], link.scl};
    n.sda_sy = {q.sda_sy[1:0], link.sda};
    // I2C target; stop and start win over bit work
    if (stop) begin
      n.ist = I_IDLE;
      n.sda_oe = 1'b0;
      if (q.ist != I_IDLE && !q.rdph && q.bytec >= 10'h002 && q.sub[SUB_WR_BIT]) // RULE_03
      begin
        n.cmd_valid = 1'b1; // RULE_09
        n.cmd_code = {8'h00, q.sub};
        n.cmd_len = 10'(q.bytec - 10'h002);
        n.cmd_read = 1'b0;
        n.cmd_usb = 1'b0;
        n.pend = 1'b0;
      end
    end else if (start) begin
      n.ist = I_RX; // RULE_01
      n.bitc = '0;
      n.bytec = '0;
      n.sda_oe = 1'b0;
    end else begin
      case (q.ist)
        I_RX:
        begin
          if (rise) begin
            n.sh = {q.sh[6:0], sda_v};
            n.bitc = q.bitc + 4'h1;
            if (q.bitc == 4'h7) begin
              n.ist = I_ACKW;
              if (q.bytec == 10'h000) begin
                n.rdph = sda_v;
                n.txptr = '0;
                if (q.sh[6:0] != i2c_wr_addr[7:1]) // RULE_02
                  n.ist = I_IDLE;
              end else if (q.bytec == 10'h001) begin
                n.sub = {q.sh[6:0], sda_v};
              end else if (q.bytec <= 10'h201) begin
                bw_en = 1'b1; // RULE_08
                bw_addr = 9'(q.bytec - 10'h002);
                bw_data = {q.sh[6:0], sda_v};
              end
            end
          end
        end
        I_ACKW:
        begin
          if (fall) begin
            n.sda_oe = 1'b1;
            n.ist = I_ACK;
          end
        end
        I_ACK:
        begin
          if (fall) begin
            n.sda_oe = 1'b0;
            n.bytec = q.bytec + 10'h001;
            n.bitc = '0;
            if (q.rdph) begin
              n.ist = I_TX; // RULE_07
              n.sda_oe = !mem_q[7];
            end else begin
              n.ist = I_RX;
              // Read command reruns with each parameter byte, last run wins
              if (q.bytec != 10'h000 && !q.sub[SUB_WR_BIT]) begin
                n.cmd_valid = 1'b1; // RULE_08
                n.cmd_code = {8'h00, q.sub};
                n.cmd_len = 10'(q.bytec - 10'h001);
                n.cmd_read = 1'b1;
                n.cmd_usb = 1'b0;
                n.pend = 1'b0;
                n.scl_oe = 1'b1; // RULE_06
                n.busy = 1'b1;
              end
            end
          end
        end
        I_TX:
        begin
          if (fall) begin
            if (q.bitc == 4'h8) begin
              n.sda_oe = 1'b0;
              n.ist = I_MACK;
            end else begin
              n.sda_oe = !mem_q[3'(4'h7 - q.bitc)];
            end
          end else if (rise) begin
            n.bitc = q.bitc + 4'h1;
          end
        end
        I_MACK:
        begin
          if (rise) begin
            n.ist = sda_v ? I_IDLE : I_TXLD;
            n.txptr = q.txptr + 10'h001;
          end
        end
        I_TXLD:
        begin
          if (fall) begin
            n.sda_oe = !mem_q[7];
            n.bitc = '0;
            n.ist = I_TX;
          end
        end
        default: n.ist = I_IDLE;
      endcase
    end
    // USB outbound reports; bytes past 65 in one transfer, report id included, are dropped
    if (link.usb_out_valid && (q.ust == U_ID || q.ucnt != USB_XFER_MAX)) begin // RULE_18
      n.ucnt = q.ucnt + 7'h01;
      case (q.ust)
        U_ID:
        begin
          n.ucnt = '0;
          if (link.usb_out_data != REPORT_ID) // RULE_11
            n.ust = U_DROP;
          else
            n.ust = q.mid ? U_DATA : U_FLAG; // RULE_19
        end
        U_FLAG:
        begin
          n.flag = link.usb_out_data; // RULE_20
          n.ust = U_SEQ; // RULE_12
        end
        U_SEQ:
        begin
          n.seq = link.usb_out_data; // RULE_15
          n.ust = U_LLO;
        end
        U_LLO:
        begin
          n.plen[7:0] = link.usb_out_data; // RULE_04
          n.ust = U_LHI;
        end
        U_LHI:
        begin
          n.plen[15:8] = link.usb_out_data;
          n.pcnt = '0;
          n.mid = ({link.usb_out_data, q.plen[7:0]} >= 16'h0002); // RULE_13
          n.ust = n.mid ? U_CLO : U_DROP;
        end
        U_CLO:
        begin
          n.clo = link.usb_out_data; // RULE_14
          n.pcnt = 16'h0001;
          n.ust = U_CHI;
        end
        U_CHI, U_DATA:
        begin
          n.pcnt = q.pcnt + 16'h0001;
          n.ust = U_DATA;
          if (q.ust == U_DATA && q.pcnt < 16'h0202) begin
            bw_en = 1'b1; // RULE_05
            bw_addr = 9'(q.pcnt - 16'h0002);
            bw_data = link.usb_out_data;
          end
          if (q.pcnt + 16'h0001 == q.plen) begin
            n.cmd_valid = 1'b1; // RULE_16
            if (q.ust == U_CHI)
              n.cmd_code = {link.usb_out_data, q.clo};
            else
              n.cmd_code = q.cmd_code;
            n.cmd_len = 10'(q.plen - 16'h0002);
            n.cmd_read = q.flag[FLAG_READ_BIT];
            n.cmd_usb = 1'b1;
            n.pend = 1'b0;
            n.mid = 1'b0;
            n.ust = U_DROP;
          end else if (q.ust == U_CHI) begin
            n.cmd_code = {link.usb_out_data, q.clo};
          end
        end
        default: n.ust = U_DROP;
      endcase
    end
    if (link.usb_out_valid && link.usb_out_last)
      n.ust = U_ID;
    // Executor answer frees SCL and arms the inbound report when a USB command wants a reply
    if (rsp_valid) begin
      n.rlen = rsp_len;
      n.rerr = rsp_err;
      n.busy = n.busy && !q.busy;
      n.scl_oe = n.busy;
      n.pend = q.cmd_usb && q.flag[FLAG_REPLY_BIT]; // RULE_17
      n.first = 1'b1;
      n.tptr = '0;
    end
    // USB inbound report, data bytes every other cycle for the buffer read
    case (q.tst)
      T_IDLE:
      begin
        if (link.usb_in_req && q.pend)
          n.tst = T_ID;
      end
      T_ID:
      begin
        n.in_data = REPORT_ID; // RULE_11
        n.in_valid = 1'b1;
        n.icnt = '0;
        n.ph = 1'b0;
        n.tst = q.first ? T_FLAG : T_DATA;
      end
      T_FLAG:
      begin
        n.in_data = q.flag;
        n.in_data[FLAG_ERR_BIT] = q.rerr; // RULE_21
        n.in_valid = 1'b1;
        n.tst = T_SEQ;
      end
      T_SEQ:
      begin
        n.in_data = q.seq; // RULE_15
        n.in_valid = 1'b1;
        n.tst = T_LLO;
      end
      T_LLO:
      begin
        n.in_data = q.rlen[7:0]; // RULE_04
        n.in_valid = 1'b1;
        n.tst = T_LHI;
      end
      T_LHI:
      begin
        n.in_data = {6'h00, q.rlen[9:8]};
        n.in_valid = 1'b1;
        n.icnt = 7'h04;
        n.first = 1'b0;
        n.tst = T_DATA;
        if (q.rlen == 10'h000) begin
          n.in_last = 1'b1;
          n.pend = 1'b0;
          n.tst = T_IDLE;
        end
      end
      T_DATA:
      begin
        n.ph = !q.ph;
        if (q.ph) begin
          n.in_data = mem_q;
          n.in_valid = 1'b1;
          n.tptr = q.tptr + 10'h001;
          n.icnt = q.icnt + 7'h01;
          if (q.tptr + 10'h001 == q.rlen) begin
            n.in_last = 1'b1;
            n.pend = 1'b0;
            n.tst = T_IDLE;
          end else if (q.icnt + 7'h01 == USB_XFER_MAX) begin
            n.in_last = 1'b1; // RULE_18
            n.tst = T_IDLE;
          end
        end
      end
      default: n.tst = T_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst)
      q <= '0;
    else
      q <= n;
  end

  // Shared buffer; executor writes win over link writes
  always_ff @(posedge clk) begin
    if (rsp_we)
      mem[rsp_addr] <= rsp_data; // RULE_05
    else if (bw_en)
      mem[bw_addr] <= bw_data;
  end

  // Registered buffer reads
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mem_q <= '0;
      buf_rdata_r <= '0;
    end else begin
      mem_q <= mem[rd_addr];
      buf_rdata_r <= mem[buf_raddr];
    end
  end

  // Outputs, pins only ever pull low
  assign link.scl_o_d = 1'b0;
  assign link.sda_o_d = 1'b0;
  assign link.scl_oe_d = q.scl_oe;
  assign link.sda_oe_d = q.sda_oe;
  assign link.usb_in_data = q.in_data;
  assign link.usb_in_valid = q.in_valid;
  assign link.usb_in_last = q.in_last;
  assign cmd_valid = q.cmd_valid;
  assign cmd_code = q.cmd_code;
  assign cmd_len = q.cmd_len;
  assign cmd_read = q.cmd_read;
  assign cmd_usb = q.cmd_usb;
  assign busy = q.busy;
  assign buf_rdata = buf_rdata_r;
endmodule : host_cmd_dev

// file: logic/host_cmd_ctl.sv
`timescale 1ns/10ps
module host_cmd_ctl
  import hcp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Link to device
  host_link_if.host link,
  // Register port
  input wire logic [9:0] addr,
  input wire logic [15:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [15:0] rdata
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_USBO, H_USBI} hst_e;

  typedef struct packed {
    logic [1:0] scl_sy;
    logic [1:0] sda_sy;
    hst_e st;
    logic [1:0] ph;
    logic [7:0] tcnt;
    logic [3:0] bitc;
    logic [9:0] idx;
    logic [9:0] cnt;
    logic [1:0] op;
    logic [7:0] sh;
    logic nack;
    logic scl_oe;
    logic sda_oe;
    logic [7:0] out_data;
    logic out_valid;
    logic out_last;
    logic in_req;
    logic [9:0] incnt;
  } host_s;

  host_s q;
  host_s n;
  logic [7:0] mem [BUF_BYTES];
  logic [7:0] mem_q;
  logic [15:0] rdata_r;
  logic bw_en;
  logic [7:0] bw_data;
  logic tick;
  logic rdb;
  logic [9:0] total;

  assign tick = (q.tcnt == QTR_CYC - 8'h01);
  assign rdb = (q.op == OP_I2C_RD) && (q.idx != 10'h000);
  assign total = (q.op == OP_I2C_RD) ? q.cnt + 10'h001 : q.cnt;

  // Operation sequencer, quarter-bit steps on the I2C side
  always_comb begin
    n = q;
    bw_en = 1'b0;
    bw_data = '0;
    n.scl_sy = {q.scl_sy[0], link.scl};
    n.sda_sy = {q.sda_sy[0], link.sda};
    n.tcnt = tick ? 8'h00 : q.tcnt + 8'h01;
    n.in_req = 1'b0;
    n.out_valid = 1'b0;
    n.out_last = 1'b0;
    if (we && addr == HREG_COUNT)
      n.cnt = wdata[9:0];
    // High time only counts once SCL is really high
    if ((q.st == H_BIT || q.st == H_STOP) && q.ph == 2'h2 && !q.scl_sy[1])
      n.tcnt = 8'h00; // RULE_06
    case (q.st)
      H_IDLE:
      begin
        n.scl_oe = 1'b0;
        n.sda_oe = 1'b0;
        if (we && addr == HREG_CTRL) begin
          n.op = wdata[1:0];
          n.idx = '0;
          n.nack = 1'b0;
          n.ph = 2'h0;
          n.bitc = '0;
          n.tcnt = 8'h00;
          n.in_req = (wdata[1:0] == OP_USB_IN); // RULE_17
          if (wdata[1])
            n.st = wdata[0] ? H_USBI : H_USBO;
          else
            n.st = H_START;
        end
      end
      H_START:
      begin
        if (tick) begin
          n.ph = q.ph + 2'h1;
          if (q.ph == 2'h0)
            n.sda_oe = 1'b1; // RULE_10
          if (q.ph == 2'h1) begin
            n.scl_oe = 1'b1;
            n.ph = 2'h0;
            n.st = H_BIT;
          end
        end
      end
      H_BIT:
      begin
        if (tick) begin
          n.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0:
            begin
              if (q.bitc == 4'h0)
                n.sh = mem_q;
              if (q.bitc == 4'h8)
                n.sda_oe = rdb && (q.idx != q.cnt);
              else
                n.sda_oe = !rdb && !((q.bitc == 4'h0) ? mem_q[7] : q.sh[7]);
            end
            2'h1: n.scl_oe = 1'b0;
            2'h2:
            begin
              if (q.bitc != 4'h8)
                n.sh = {q.sh[6:0], q.sda_sy[1]};
              else if (!rdb)
                n.nack = q.nack || q.sda_sy[1];
            end
            default:
            begin
              n.scl_oe = 1'b1;
              n.bitc = q.bitc + 4'h1;
              if (q.bitc == 4'h8) begin
                n.bitc = '0;
                bw_en = rdb; // RULE_07
                bw_data = q.sh;
                n.idx = q.idx + 10'h001;
                if (q.idx + 10'h001 == total)
                  n.st = H_STOP; // RULE_09
              end
            end
          endcase
        end
      end
      H_STOP:
      begin
        if (tick) begin
          n.ph = q.ph + 2'h1;
          if (q.ph == 2'h0)
            n.sda_oe = 1'b1;
          if (q.ph == 2'h1)
            n.scl_oe = 1'b0;
          if (q.ph == 2'h2) begin
            n.sda_oe = 1'b0; // RULE_01
            n.st = H_IDLE;
          end
        end
      end
      H_USBO:
      begin
        // Every other cycle so the buffer read can follow the index
        n.ph = {1'b0, !q.ph[0]};
        if (q.cnt == 10'h000) begin
          n.st = H_IDLE;
        end else if (q.ph[0]) begin
          n.out_data = mem_q; // RULE_16
          n.out_valid = 1'b1;
          n.idx = q.idx + 10'h001;
          if (q.idx + 10'h001 == q.cnt) begin
            n.out_last = 1'b1;
            n.st = H_IDLE;
          end
        end
      end
      H_USBI:
      begin
        if (link.usb_in_valid) begin
          bw_en = 1'b1;
          bw_data = link.usb_in_data;
          n.idx = q.idx + 10'h001;
          n.tcnt = 8'h00;
          if (link.usb_in_last) begin
            n.incnt = q.idx + 10'h001;
            n.st = H_IDLE;
          end
        end else if (q.tcnt == IN_WAIT_CYC) begin
          n.incnt = q.idx;
          n.st = H_IDLE;
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (!nrst)
      q <= '0;
    else
      q <= n;
  end

  // Buffer; engine writes win over software writes, which land in any state
  always_ff @(posedge clk) begin
    if (bw_en)
      mem[q.idx[8:0]] <= bw_data;
    else if (we && !addr[9])
      mem[addr[8:0]] <= wdata[7:0];
    mem_q <= mem[q.idx[8:0]];
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!nrst || !re)
      rdata_r <= '0;
    else if (!addr[9])
      rdata_r <= {8'h00, mem[addr[8:0]]};
    else if (addr == HREG_CTRL)
      rdata_r <= {14'h0000, q.op};
    else if (addr == HREG_COUNT)
      rdata_r <= {6'h00, q.cnt};
    else if (addr == HREG_STATUS)
      rdata_r <= {14'h0000, q.nack, q.st != H_IDLE};
    else if (addr == HREG_INCNT)
      rdata_r <= {6'h00, q.incnt};
    else
      rdata_r <= '0;
  end

  // Outputs
  assign link.scl_o_h = 1'b0;
  assign link.sda_o_h = 1'b0;
  assign link.scl_oe_h = q.scl_oe;
  assign link.sda_oe_h = q.sda_oe;
  assign link.usb_out_data = q.out_data;
  assign link.usb_out_valid = q.out_valid;
  assign link.usb_out_last = q.out_last;
  assign link.usb_in_req = q.in_req;
  assign rdata = rdata_r;
endmodule : host_cmd_ctl

// file: verification/hcp_checker.sv
`timescale 1ns/10ps
module hcp_checker
  import hcp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Wired bus
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe_d,
  input wire logic sda_oe_d,
  // Report streams
  input wire logic [7:0] usb_out_data,
  input wire logic usb_out_valid,
  input wire logic usb_out_last,
  input wire logic usb_in_req,
  input wire logic [7:0] usb_in_data,
  input wire logic usb_in_valid,
  input wire logic usb_in_last
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  logic out_first_r;
  logic in_open_r;
  logic [6:0] in_cnt_r;

  // Transfer position, reset by each last byte
  always_ff @(posedge clk)
  begin
    if (!nrst)
    begin
      out_first_r <= 1'b1;
      in_open_r <= 1'b0;
      in_cnt_r <= 7'h00;
    end
    else
    begin
      if (usb_out_valid)
        out_first_r <= usb_out_last;
      if (usb_in_req)
        in_open_r <= 1'b1;
      else if (usb_in_valid && usb_in_last)
        in_open_r <= 1'b0;
      if (usb_in_valid)
        in_cnt_r <= usb_in_last ? 7'h00 : in_cnt_r + 7'h01;
    end
  end

  AST_OUT_ID: assert property (usb_out_valid && out_first_r |-> usb_out_data == 8'h00)
    else $error("outbound lead byte not zero");
  AST_IN_ID: assert property (usb_in_valid && in_cnt_r == 7'h00 |-> usb_in_data == 8'h00)
    else $error("inbound lead byte not zero");
  AST_IN_MAX: assert property (usb_in_valid && in_cnt_r == 7'h40 |-> usb_in_last)
    else $error("inbound transfer too long");
  AST_IN_REQ: assert property (usb_in_valid |-> in_open_r)
    else $error("inbound byte without request");
  AST_START: assert property ($fell(sda) && scl |-> !sda throughout (scl ##[1:400] !scl))
    else $error("start not followed by clock fall");
  AST_STOP: assert property ($rose(sda) && scl |-> (scl && sda) [*8])
    else $error("bus not idle after stop");
  AST_STRETCH_LOW: assert property ($rose(scl_oe_d) |-> !$past(scl))
    else $error("stretch began on a high clock");
  AST_STRETCH_END: assert property ($rose(scl_oe_d) |-> ##[1:600] !scl_oe_d)
    else $error("stretch never released");
  AST_DEV_SDA: assert property ($changed(sda_oe_d) |-> !scl)
    else $error("data moved while clock high");

  // Main traffic seen
  cover property (usb_in_valid && usb_in_last);
  cover property ($rose(scl_oe_d));
  cover property (usb_out_valid && usb_out_last);
endmodule : hcp_checker

// file: verification/testbench.sv
`timescale 1ns/10ps
module testbench
  import hcp_pkg::*;
;
  logic clk, nrst = 1'b0, we = 1'b0, re = 1'b0, rsp_we = 1'b0, rsp_valid = 1'b0, wb = 1'b0;
  logic rsp_err, cmd_valid, cmd_read, cmd_usb, busy;
  logic [9:0] addr = 10'h000, cmd_len, rsp_len = 10'h000;
  logic [15:0] wdata = 16'h0000, rdata, cmd_code, s;
  logic [7:0] i2c_wr_addr, rsp_data = 8'h00, buf_rdata, adr, pk [0:15], rb [0:2], hdr [0:4];
  logic [8:0] buf_raddr = 9'h000, rsp_addr = 9'h000;
  logic [27:0] exp_q [$], got_q [$];
  int n_fail = 0, checks = 0, seed = 25014, rsp_n = 0, wi = 0, i;
  host_link_if link ();
  host_cmd_ctl host_cmd_ctl_i (.*);
  host_cmd_dev host_cmd_dev_i (.*);
  hcp_checker hcp_checker_i (.clk, .nrst, .scl(link.scl), .sda(link.sda),
    .scl_oe_d(link.scl_oe_d), .sda_oe_d(link.sda_oe_d), .usb_out_data(link.usb_out_data),
    .usb_out_valid(link.usb_out_valid), .usb_out_last(link.usb_out_last),
    .usb_in_req(link.usb_in_req), .usb_in_data(link.usb_in_data),
    .usb_in_valid(link.usb_in_valid), .usb_in_last(link.usb_in_last));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Executor stand-in answers all, ending stretches
  always @(posedge clk)
  begin
    rsp_we <= 1'b0;
    rsp_valid <= 1'b0;
    if (cmd_valid === 1'b1)
    begin
      chk("busy", 32'(exp_q[got_q.size()][27:26] == 2'b01), 32'(busy));
      got_q.push_back({cmd_usb, cmd_read, cmd_len, cmd_code});
      wi <= 0;
      wb <= 1'b1;
    end
    else if (wb && wi < rsp_n)
    begin
      rsp_we <= 1'b1;
      rsp_addr <= 9'(wi);
      rsp_data <= rb[wi];
      wi <= wi + 1;
    end
    else if (wb)
    begin
      rsp_valid <= 1'b1;
      rsp_len <= 10'(rsp_n);
      wb <= 1'b0;
    end
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task give_verdict;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task wr(input logic [9:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
    @(posedge clk);
  endtask : wr

  task rd(input logic [9:0] a);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 s = rdata;
    @(posedge clk);
  endtask : rd

  // Load bytes, start an op, poll until idle; a hang ends the run
  task run(input int n, input int cnt, input logic [1:0] op);
    int k;
    for (k = 0; k < n; k++)
      wr(10'(k), {8'h00, pk[k]});
    wr(HREG_COUNT, 16'(cnt));
    wr(HREG_CTRL, {14'h0000, op});
    s = 16'h0001;
    for (k = 0; k < 20000 && s[ST_BUSY_BIT] !== 1'b0; k++)
      rd(HREG_STATUS);
    chk("idle", 32'h0, 32'(s[ST_BUSY_BIT]));
    if (s[ST_BUSY_BIT] !== 1'b0)
      give_verdict();
    repeat (20) @(posedge clk);
  endtask : run

  task cmp(input string t);
    chk("cmd count", 32'(exp_q.size()), 32'(got_q.size()));
    for (i = 0; i < exp_q.size() && i < got_q.size(); i++)
      chk("cmd", 32'(exp_q[i]), 32'(got_q[i]));
    exp_q.delete();
    got_q.delete();
    $display("test %s done", t);
  endtask : cmp

  task par(input int k, input logic [7:0] e);
    buf_raddr <= 9'(k);
    repeat (2) @(posedge clk);
    #1 chk("param", 32'(e), 32'(buf_rdata));
    @(posedge clk);
  endtask : par

  initial
  begin
    for (i = 0; i < 16; i++)
      pk[i] = 8'($random(seed));
    for (i = 0; i < 3; i++)
      rb[i] = 8'($random(seed));
    adr = {1'b1, pk[15][5:0], 1'b0};
    i2c_wr_addr = adr;
    rsp_err = pk[14][0];
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    // Two-wire write, two data bytes
    pk[0] = adr;
    pk[1] = pk[1] | 8'h80;
    exp_q.push_back({2'b00, 10'd2, 8'h00, pk[1]});
    run(4, 4, OP_I2C_WR);
    chk("nack", 32'h0, 32'(s[ST_NACK_BIT]));
    cmp("i2c write");
    par(0, pk[2]);
    par(1, pk[3]);
    // Read code with a parameter, then fetch
    pk[1] = pk[1] & 8'h7F;
    rsp_n = 3;
    exp_q.push_back({2'b01, 10'd0, 8'h00, pk[1]});
    exp_q.push_back({2'b01, 10'd1, 8'h00, pk[1]});
    run(3, 3, OP_I2C_WR);
    cmp("i2c read command");
    pk[0] = adr | 8'h01;
    run(1, 3, OP_I2C_RD);
    for (i = 0; i < 3; i++)
    begin
      rd(10'(i + 1));
      chk("fetch", 32'(rb[i]), 32'(s[7:0]));
    end
    // Outbound write report, three data bytes
    pk[0] = 8'h00;
    pk[1] = 8'h00;
    pk[3] = 8'h05;
    pk[4] = 8'h00;
    rsp_n = 0;
    exp_q.push_back({2'b10, 10'd3, pk[6], pk[5]});
    run(10, 10, OP_USB_OUT);
    cmp("usb write");
    for (i = 0; i < 3; i++)
      par(i, pk[i + 7]);
    // Read report wanting a reply, fetched inbound
    pk[1] = 8'hC0;
    pk[3] = 8'h02;
    rsp_n = 3;
    exp_q.push_back({2'b11, 10'd0, pk[6], pk[5]});
    run(7, 7, OP_USB_OUT);
    cmp("usb read");
    run(0, 0, OP_USB_IN);
    rd(HREG_INCNT);
    chk("in count", 32'd8, 32'(s));
    hdr = '{8'h00, {2'b11, rsp_err, 5'h00}, pk[2], 8'h03, 8'h00};
    for (i = 0; i < 8; i++)
    begin
      rd(10'(i));
      chk("inbound", 32'(i < 5 ? hdr[i] : rb[i - 5]), 32'(s[7:0]));
    end
    // Foreign address stays unanswered
    pk[0] = adr ^ 8'h02;
    run(2, 2, OP_I2C_WR);
    chk("nack", 32'h1, 32'(s[ST_NACK_BIT]));
    cmp("foreign address");
    give_verdict();
  end
endmodule : testbench
